// [fifo_cascade_pkg.sv]
// Shared constants for the cascadable 18-bit FIFO stage and its expansion controller.
// Assumes one core clock drives every stage of a chain and the controller.
package fifo_cascade_pkg;
	// Word and array geometry of one stage
	localparam int          DATA_W   = 18;
	localparam int          ADDR_W   = 15;
	localparam int          CNT_W    = 16;
	localparam int          TOT_W    = 17;
	localparam int          DEPTH    = 32768;
	localparam int          PEERS    = 1;
	// Depth used by the flag arithmetic in each timing mode
	localparam logic [16:0] DEPTH_LEGACY = 17'h08000;
	localparam logic [16:0] DEPTH_FALL   = 17'h08001;
	// Half-full trips when the word count rises above these
	localparam logic [16:0] HALF_LEGACY  = DEPTH_LEGACY >> 1;
	localparam logic [16:0] HALF_FALL    = ((DEPTH_FALL - 17'h00001) >> 1) + 17'h00001;
	// Almost-empty margin added in fall-through mode
	localparam logic [16:0] AE_FALL_EXTRA = 17'h00001;
	// Values after reset
	localparam logic [14:0] EMPTY_OFS_RST = 15'h0007;
	localparam logic [3:0]  MRS_CYCLES    = 4'h3;
	// Worst-case chain latencies, in transfer-clock and port-clock periods
	localparam int          RIPPLE_XFER_CYC = 4;
	localparam int          RIPPLE_RCLK_CYC = 3;
	localparam int          BUBBLE_XFER_CYC = 3;
	localparam int          BUBBLE_WCLK_CYC = 2;
	// Controller state
	typedef enum logic [1:0] {CTL_RESET, CTL_RUN} ctl_state_type;
endpackage

// [fifo_link_if.sv]
// Link between one FIFO stage and its expansion controller.
// Assumes both ends run on the same core clock.
`timescale 1ns/10ps
`default_nettype none
interface fifo_link_if;
	logic [17:0] data_in;             // Word written into the stage
	logic        write_en_n;          // Write strobe, active low
	logic        full_flag_n;         // Full (legacy) or input ready (fall-through)
	logic        empty_flag_n;        // Empty (legacy) or output ready (fall-through)
	logic        half_full_flag_n;    // Low above half depth
	logic        almost_empty_flag_n; // Low at or below the empty offset, or offset plus one in fall-through
	logic        fall_through_mode;   // Mode strap, caught during master reset
	logic        master_reset_n;      // Clears the stage, active low
	logic [14:0] empty_offset;        // Almost-empty offset

	modport dev (
		input  data_in, write_en_n, fall_through_mode, master_reset_n, empty_offset,
		output full_flag_n, empty_flag_n, half_full_flag_n, almost_empty_flag_n
	);
	modport ctl (
		output data_in, write_en_n, fall_through_mode, master_reset_n, empty_offset,
		input  full_flag_n, empty_flag_n, half_full_flag_n, almost_empty_flag_n
	);
endinterface
`default_nettype wire

// [fifo_stage.sv]
// One cascadable FIFO stage: write port and status on the link, read port on plain pins.
// Assumes the read port feeds the next stage or the final consumer on the same clock.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// RULE1: Late almost-empty release tolerated under skew
// RULE2: Fall-through flag depth is array plus one
// RULE3: Legacy flag depth equals array size
// RULE4: Controls tied together; any status shared
// RULE5: Empty/full edges may differ one cycle
// RULE6: Legacy composite flags by ANDing per flag
// RULE7: Fall-through composite flags by ORing per flag
// RULE8: No wired outputs; equal depths in bank
// RULE9: Chains need fall-through chosen at reset
// RULE10: Outputs feed next inputs; depths add
// RULE11: Read clock must run continuously
// RULE12: Output-ready low drives next write enable
// RULE13: First word ripples within stated latency
// RULE14: Later words pass with no added delay
// RULE15: Input-ready low drives previous read enable
// RULE16: Free space bubbles up within stated latency
// RULE17: Transfer clock tied to faster clock
// RULE18: Half-full after D/2+1 or (D-1)/2+2 writes
// RULE19: Almost-empty at n or n+1 words
module fifo_stage (
	input  wire logic                                i_core_clk,  // Core clock, 40 MHz
	input  wire logic                                i_rst_n,     // Synchronous reset
	fifo_link_if.dev                                 link,        // Write port and status
	input  wire logic                                i_rd_en_n,   // Read enable, active low
	output logic [fifo_cascade_pkg::DATA_W-1:0]      o_data_out,  // Read data
	output logic                                     o_out_rdy_n  // Empty / output ready
);
	logic [fifo_cascade_pkg::DATA_W-1:0] mem_r [fifo_cascade_pkg::DEPTH];
	logic [fifo_cascade_pkg::ADDR_W-1:0] wr_ptr_r;
	logic [fifo_cascade_pkg::ADDR_W-1:0] rd_ptr_r;
	logic [fifo_cascade_pkg::CNT_W-1:0]  arr_cnt_r;
	logic [fifo_cascade_pkg::CNT_W-1:0]  arr_cnt_nxt;
	logic                                out_vld_r;
	logic                                out_vld_nxt;
	logic                                fall_r;
	logic                                clr;
	logic                                wr_do;
	logic                                arr_rd;
	logic                                out_take;
	logic [fifo_cascade_pkg::TOT_W-1:0]  tot_nxt;
	logic [fifo_cascade_pkg::TOT_W-1:0]  ae_lim;
	logic [fifo_cascade_pkg::TOT_W-1:0]  half_lim;
	logic                                arr_full;
	logic                                arr_empty;
	logic                                full_n_r;
	logic                                empty_n_r;
	logic                                half_n_r;
	logic                                ae_n_r;

	// Either reset clears pointers and data state
	assign clr       = !i_rst_n || !link.master_reset_n;
	assign arr_full  = arr_cnt_r == fifo_cascade_pkg::CNT_W'(fifo_cascade_pkg::DEPTH);
	assign arr_empty = arr_cnt_r == '0;

	// Mode strap is sampled only while master reset is held
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			fall_r <= 1'b0;
		end else if (!link.master_reset_n) begin
			fall_r <= link.fall_through_mode; // RULE9
		end
	end

	// Write accept and array read decisions
	always_comb begin
		wr_do    = !link.write_en_n && !arr_full && !clr;
		out_take = 1'b0;
		arr_rd   = 1'b0;
		if (fall_r) begin
			// Head word is pulled by the next stage's input-ready, no explicit read
			out_take = !i_rd_en_n && out_vld_r; // RULE15
			arr_rd   = !arr_empty && (!out_vld_r || out_take); // RULE11
		end else begin
			arr_rd   = !i_rd_en_n && !arr_empty;
		end
		if (clr) begin
			out_take = 1'b0;
			arr_rd   = 1'b0;
		end
	end

	// Next occupancy of the array and of the fall-through output register
	always_comb begin
		arr_cnt_nxt = arr_cnt_r;
		if (wr_do && !arr_rd) begin
			arr_cnt_nxt = arr_cnt_r + 16'h0001;
		end else if (!wr_do && arr_rd) begin
			arr_cnt_nxt = arr_cnt_r - 16'h0001;
		end
		out_vld_nxt = out_vld_r;
		if (fall_r) begin
			out_vld_nxt = arr_rd || (out_vld_r && !out_take);
		end
		if (clr) begin
			arr_cnt_nxt = '0;
			out_vld_nxt = 1'b0;
		end
	end

	// Word count seen by the flags includes the output register in fall-through
	assign tot_nxt = {1'b0, arr_cnt_nxt} + {16'h0000, out_vld_nxt};

	// Flag thresholds follow the depth of the active mode
	always_comb begin
		if (fall_r) begin
			half_lim = fifo_cascade_pkg::HALF_FALL; // RULE2
			ae_lim   = {2'b00, link.empty_offset} + fifo_cascade_pkg::AE_FALL_EXTRA; // RULE19
		end else begin
			half_lim = fifo_cascade_pkg::HALF_LEGACY; // RULE3
			ae_lim   = {2'b00, link.empty_offset}; // RULE19
		end
	end

	// Storage write; data outputs of one stage feed the next with no glue
	always_ff @(posedge i_core_clk) begin
		if (wr_do) begin
			mem_r[wr_ptr_r] <= link.data_in; // RULE10
		end
	end

	// Pointers
	always_ff @(posedge i_core_clk) begin
		if (clr) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			if (wr_do) begin
				wr_ptr_r <= wr_ptr_r + 15'h0001;
			end
			if (arr_rd) begin
				rd_ptr_r <= rd_ptr_r + 15'h0001;
			end
		end
	end

	// Occupancy registers
	always_ff @(posedge i_core_clk) begin
		arr_cnt_r <= arr_cnt_nxt;
		out_vld_r <= out_vld_nxt;
	end

	// Read data: loaded on a legacy read or when the head register refills
	always_ff @(posedge i_core_clk) begin
		if (clr) begin
			o_data_out <= '0;
		end else if (arr_rd) begin
			o_data_out <= mem_r[rd_ptr_r]; // RULE14
		end
	end

	// Flags are computed from the next state, so they change on the same edge
	// as the data; a single clock leaves no skew, so no late release occurs
	always_ff @(posedge i_core_clk) begin
		if (clr) begin
			full_n_r  <= 1'b1;
			// Output ready stays high (no word) while a fall-through stage clears
			empty_n_r <= fall_r; // RULE12
			half_n_r  <= 1'b1;
			ae_n_r    <= 1'b0;
		end else begin
			if (fall_r) begin
				// Active-low ready flags: low means a word waits / room exists
				empty_n_r <= !out_vld_nxt; // RULE12 RULE13
				full_n_r  <= arr_cnt_nxt == fifo_cascade_pkg::CNT_W'(fifo_cascade_pkg::DEPTH); // RULE16
			end else begin
				empty_n_r <= arr_cnt_nxt != '0;
				full_n_r  <= arr_cnt_nxt != fifo_cascade_pkg::CNT_W'(fifo_cascade_pkg::DEPTH);
			end
			half_n_r <= !(tot_nxt > half_lim); // RULE18
			ae_n_r   <= tot_nxt > ae_lim; // RULE1 RULE19
		end
	end

	// The same flops serve the link and the read pins; the skew
	// tolerance of a bank is absorbed by the controller's composite
	assign link.full_flag_n         = full_n_r; // RULE5
	assign link.empty_flag_n        = empty_n_r;
	assign link.half_full_flag_n    = half_n_r;
	assign link.almost_empty_flag_n = ae_n_r;
	assign o_out_rdy_n              = empty_n_r;
endmodule
`default_nettype wire

// [fifo_expand_ctl.sv]
// Expansion controller: buffers user writes, drives master reset and mode,
// and forms composite flags across a width-expanded bank.
// Assumes peer stages share this controller's write strobe and data slices.
`timescale 1ns/10ps
`default_nettype none
module fifo_expand_ctl (
	input  wire logic                                 i_core_clk,    // Core clock, 40 MHz
	input  wire logic                                 i_rst_n,       // Synchronous reset
	fifo_link_if.ctl                                  link,          // Stage write port
	input  wire logic                                 i_fall_sel,    // Fall-through select
	input  wire logic [14:0]                          i_empty_ofs,   // Almost-empty offset
	input  wire logic                                 i_wr_valid,    // User word valid
	input  wire logic [fifo_cascade_pkg::DATA_W-1:0]  i_wr_data,     // User word
	output logic                                      o_wr_ready,    // Buffer has room
	input  wire logic [fifo_cascade_pkg::PEERS-1:0]   i_peer_full_n, // Peer full / input ready
	input  wire logic [fifo_cascade_pkg::PEERS-1:0]   i_peer_empty_n,// Peer empty / out ready
	output logic                                      o_comp_full_n, // Composite full flag
	output logic                                      o_comp_empty_n // Composite empty flag
);
	fifo_cascade_pkg::ctl_state_type state_r;
	logic [3:0]                          rst_cnt_r;
	logic [fifo_cascade_pkg::DATA_W-1:0] buf_r [2];
	logic                                buf_wp_r;
	logic                                buf_rp_r;
	logic [1:0]                          buf_cnt_r;
	logic                                push;
	logic                                pop;
	logic                                room;
	logic                                fall_r;
	logic                                mrs_n_r;
	logic                                wen_n_r;
	logic [fifo_cascade_pkg::DATA_W-1:0] din_r;
	logic [14:0]                         ofs_r;

	// Legacy flags are active-low "not empty/not full": AND them; ready flags OR
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_comp_full_n  <= 1'b1;
			o_comp_empty_n <= 1'b1;
		end else if (fall_r) begin
			o_comp_full_n  <= link.full_flag_n | (|i_peer_full_n); // RULE7
			o_comp_empty_n <= link.empty_flag_n | (|i_peer_empty_n); // RULE7
		end else begin
			o_comp_full_n  <= link.full_flag_n & (&i_peer_full_n); // RULE6
			o_comp_empty_n <= link.empty_flag_n & (&i_peer_empty_n); // RULE6
		end
	end

	// Master reset is held a few cycles with the mode strap steady
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			state_r   <= fifo_cascade_pkg::CTL_RESET;
			rst_cnt_r <= '0;
			mrs_n_r   <= 1'b0;
		end else begin
			case (state_r)
				fifo_cascade_pkg::CTL_RESET: begin
					rst_cnt_r <= rst_cnt_r + 4'h1;
					if (rst_cnt_r == fifo_cascade_pkg::MRS_CYCLES) begin
						state_r <= fifo_cascade_pkg::CTL_RUN;
						mrs_n_r <= 1'b1;
					end
				end
				fifo_cascade_pkg::CTL_RUN: begin
					mrs_n_r <= 1'b1;
				end
				default: begin
					state_r <= fifo_cascade_pkg::CTL_RESET;
				end
			endcase
		end
	end

	// Strap and offset are only changed under reset
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			fall_r <= 1'b0;
			ofs_r  <= fifo_cascade_pkg::EMPTY_OFS_RST;
		end else if (state_r == fifo_cascade_pkg::CTL_RESET) begin
			fall_r <= i_fall_sel; // RULE9
			ofs_r  <= i_empty_ofs;
		end
	end

	// Room in the whole bank, taken from the composite flag; a write is
	// issued only every other cycle, yet the flag seen at the next issue does not yet count the last one
	assign room = fall_r ? !o_comp_full_n : o_comp_full_n; // RULE4 RULE8
	assign push = i_wr_valid && o_wr_ready;
	assign pop  = buf_cnt_r != 2'h0 && room && wen_n_r && mrs_n_r;

	// Two-entry buffer: a stalled bank backs up into o_wr_ready; a write issued just after the bank fills is dropped by the full stage
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			buf_wp_r   <= 1'b0;
			buf_rp_r   <= 1'b0;
			buf_cnt_r  <= 2'h0;
			o_wr_ready <= 1'b0;
		end else begin
			if (push) begin
				buf_r[buf_wp_r] <= i_wr_data;
				buf_wp_r        <= !buf_wp_r;
			end
			if (pop) begin
				buf_rp_r <= !buf_rp_r;
			end
			buf_cnt_r  <= buf_cnt_r + {1'b0, push} - {1'b0, pop};
			o_wr_ready <= (buf_cnt_r + {1'b0, push} - {1'b0, pop}) != 2'h2;
		end
	end

	// Registered write strobe and data toward the stage
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			wen_n_r <= 1'b1;
			din_r   <= '0;
		end else begin
			wen_n_r <= !pop;
			if (pop) begin
				din_r <= buf_r[buf_rp_r];
			end
		end
	end

	assign link.write_en_n        = wen_n_r;
	assign link.data_in           = din_r;
	assign link.master_reset_n    = mrs_n_r;
	assign link.fall_through_mode = fall_r;
	assign link.empty_offset      = ofs_r;
endmodule
`default_nettype wire

// [fifo_link_assertions.sv]
// Concurrent checks on the link between the expansion controller and one stage.
// Assumes one core clock and the synchronous active-low reset of the bench.
`timescale 1ns/10ps
`default_nettype none
module fifo_link_assertions (
	input  wire logic i_core_clk,          // Core clock
	input  wire logic i_rst_n,             // Synchronous reset
	input  wire logic write_en_n,          // Write strobe
	input  wire logic full_flag_n,         // Full or input ready
	input  wire logic empty_flag_n,        // Empty or output ready
	input  wire logic half_full_flag_n,    // Half-full flag
	input  wire logic almost_empty_flag_n, // Almost-empty flag
	input  wire logic fall_through_mode,   // Mode strap
	input  wire logic master_reset_n       // Stage clear
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	// Strobe pacing and reset ordering
	a_write_spacing: assert property (!write_en_n |=> write_en_n)
		else $error("write strobes closer than two cycles");
	a_no_write_reset: assert property (!master_reset_n |-> write_en_n)
		else $error("write during stage clear");
	a_mode_held: assert property (master_reset_n && $past(master_reset_n) |-> $stable(fall_through_mode))
		else $error("mode changed outside stage clear");
	// First word into an empty fall-through stage reaches the output within three cycles
	a_first_word: assert property (fall_through_mode && master_reset_n && !write_en_n
		&& empty_flag_n |-> ##[1:3] !empty_flag_n)
		else $error("first word late at output");
	// An empty stage is always below the almost-empty margin, and a half-full one is above it
	a_empty_ae_low: assert property (master_reset_n && $past(master_reset_n, 2)
		&& (fall_through_mode ? empty_flag_n : !empty_flag_n) |-> !almost_empty_flag_n)
		else $error("almost-empty high while empty");
	a_half_over_ae: assert property (master_reset_n && !half_full_flag_n |-> almost_empty_flag_n)
		else $error("half-full with few words");
	// Fill levels only rise on a write; room returns within two cycles of a stage clear
	a_half_on_write: assert property ($fell(half_full_flag_n) |-> !$past(write_en_n))
		else $error("half-full fell without a write");
	a_ae_on_write: assert property ($rose(almost_empty_flag_n) |-> !$past(write_en_n))
		else $error("almost-empty rose without a write");
	a_legacy_fill: assert property (!fall_through_mode && $rose(empty_flag_n) |-> !$past(write_en_n))
		else $error("empty released without a write");
	a_room_after_clear: assert property ($rose(master_reset_n) |-> ##[0:2]
		(fall_through_mode ? !full_flag_n : full_flag_n))
		else $error("no room after stage clear");

	c_first_word: cover property (fall_through_mode && $fell(empty_flag_n));
	c_half_full: cover property ($fell(half_full_flag_n));
	c_ae_release: cover property ($rose(almost_empty_flag_n));
endmodule
`default_nettype wire

// [fifo_width_depth_cascade_tb.sv]
// Self-checking bench: controller and stage joined by the link, user sides driven here.
// Assumes the offset strap stays fixed; the mode changes only across a reset.
`timescale 1ns/10ps
`default_nettype none
module fifo_width_depth_cascade_tb;
	localparam int EMPTY_N = 7;
	logic        i_core_clk     = 1'h0;
	logic        i_rst_n        = 1'h0;
	logic        i_fall_sel     = 1'h1;
	logic        i_wr_valid     = 1'h0;
	logic [17:0] i_wr_data      = 18'h00000;
	logic [0:0]  i_peer_full_n  = 1'h1;
	logic [0:0]  i_peer_empty_n = 1'h1;
	logic        i_rd_en_n      = 1'h1;
	logic        o_wr_ready, o_comp_full_n, o_comp_empty_n, o_out_rdy_n;
	logic [17:0] o_data_out;
	logic        rd_on = 1'h0, pend = 1'h0, rst_d = 1'h0, cf_e, ce_e;
	logic [17:0] exp_q[$];
	int          errors = 0, checks = 0;

	fifo_link_if fifo_link_if_i ();
	fifo_expand_ctl fifo_expand_ctl_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
		.link(fifo_link_if_i.ctl), .i_fall_sel(i_fall_sel), .i_empty_ofs(15'h0007),
		.i_wr_valid(i_wr_valid), .i_wr_data(i_wr_data), .o_wr_ready(o_wr_ready),
		.i_peer_full_n(i_peer_full_n), .i_peer_empty_n(i_peer_empty_n),
		.o_comp_full_n(o_comp_full_n), .o_comp_empty_n(o_comp_empty_n));
	fifo_stage fifo_stage_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
		.link(fifo_link_if_i.dev), .i_rd_en_n(i_rd_en_n), .o_data_out(o_data_out),
		.o_out_rdy_n(o_out_rdy_n));
	fifo_link_assertions fifo_link_assertions_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
		.write_en_n(fifo_link_if_i.write_en_n), .full_flag_n(fifo_link_if_i.full_flag_n),
		.empty_flag_n(fifo_link_if_i.empty_flag_n),
		.half_full_flag_n(fifo_link_if_i.half_full_flag_n),
		.almost_empty_flag_n(fifo_link_if_i.almost_empty_flag_n),
		.fall_through_mode(fifo_link_if_i.fall_through_mode),
		.master_reset_n(fifo_link_if_i.master_reset_n));

	// 40 MHz core clock
	initial begin
		forever #12.5 i_core_clk = ~i_core_clk;
	end

	task automatic check(input logic [17:0] seen, input logic [17:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Peer flags and read strobe wander at random so stalls hit the stage;
	// during the fill the peer reports room so level checks see a drained buffer
	always @(posedge i_core_clk) begin
		i_peer_full_n  <= rd_on ? 1'($urandom) : !i_fall_sel;
		i_peer_empty_n <= 1'($urandom);
		i_rd_en_n      <= rd_on ? 1'($urandom) : 1'h1;
	end

	// Scoreboard: fall-through reads are judged at the taking edge, legacy one edge later
	always @(posedge i_core_clk) begin
		if (i_rst_n && pend) begin
			if (exp_q.size() == 0) check(o_data_out, ~o_data_out);
			else check(o_data_out, exp_q.pop_front());
		end
		if (i_rst_n && rst_d) begin
			check({17'h00000, o_comp_full_n}, {17'h00000, cf_e});
			check({17'h00000, o_comp_empty_n}, {17'h00000, ce_e});
		end
		pend  = i_rst_n && !i_rd_en_n && (i_fall_sel ? !o_out_rdy_n : o_out_rdy_n);
		if (pend && i_fall_sel) begin
			if (exp_q.size() == 0) check(o_data_out, ~o_data_out);
			else check(o_data_out, exp_q.pop_front());
			pend = 1'h0;
		end
		cf_e  = i_fall_sel ? (fifo_link_if_i.full_flag_n | i_peer_full_n[0])
			: (fifo_link_if_i.full_flag_n & i_peer_full_n[0]);
		ce_e  = i_fall_sel ? (fifo_link_if_i.empty_flag_n | i_peer_empty_n[0])
			: (fifo_link_if_i.empty_flag_n & i_peer_empty_n[0]);
		// Mode is only settled once the stage clear is over
		rst_d = i_rst_n && fifo_link_if_i.master_reset_n;
	end

	// Holds valid until accepted; never lowers it, so back-to-back pushes stay clean
	task automatic push(input logic [17:0] w);
		int n;
		n = 0;
		i_wr_valid <= 1'h1;
		i_wr_data  <= w;
		@(posedge i_core_clk);
		while (o_wr_ready !== 1'h1 && n < 1000) begin
			n++;
			@(posedge i_core_clk);
		end
		if (n >= 1000) errors++;
		exp_q.push_back(w);
	endtask

	task automatic run_mode(input logic fall, input int fill);
		int thr, half, n;
		thr  = EMPTY_N + int'(fall);
		half = fall ? (32769 - 1) / 2 + 1 : 32768 / 2;
		i_rst_n    <= 1'h0;
		i_fall_sel <= fall;
		rd_on      <= 1'h0;
		repeat (6) @(posedge i_core_clk);
		exp_q.delete();
		i_rst_n <= 1'h1;
		// Fill without reads, sampling almost-empty around its threshold and both flags at the last two words
		for (int k = 1; k <= fill; k++) begin
			push(k == 1 ? 18'h3ffff : (k == 2 ? 18'h00000 : 18'($urandom)));
			if (k == thr || k == thr + 1 || k >= fill - 1) begin
				i_wr_valid <= 1'h0;
				repeat (8) @(posedge i_core_clk);
				check({17'h00000, fifo_link_if_i.almost_empty_flag_n}, {17'h00000, k > thr});
				check({17'h00000, fifo_link_if_i.half_full_flag_n}, {17'h00000, k <= half});
			end
		end
		// Mixed traffic with random gaps while the reader stalls at random
		rd_on <= 1'h1;
		for (int k = 0; k < 300; k++) begin
			push(18'($urandom));
			if ($urandom % 4 == 0) begin
				i_wr_valid <= 1'h0;
				repeat ($urandom % 3 + 1) @(posedge i_core_clk);
			end
		end
		i_wr_valid <= 1'h0;
		n = 0;
		while (exp_q.size() != 0 && n < 60000) begin
			n++;
			@(posedge i_core_clk);
		end
		if (n >= 60000) errors++;
		repeat (3) @(posedge i_core_clk);
		check({17'h00000, o_out_rdy_n}, {17'h00000, fall});
	endtask

	initial begin
		void'($urandom(32'he7d672d6));
		run_mode(1'h1, 16386);
		run_mode(1'h0, 20);
		finish_test();
	end

	// The run needs about 70k cycles; a hang is cut before 100k
	initial begin
		repeat (95000) @(posedge i_core_clk);
		errors++;
		finish_test();
	end
endmodule
`default_nettype wire
